// file: hw/mlcr_pkg.sv
// package: line control register layout, call states and timing counts
package mlcr_pkg;
  localparam int unsigned ClkHz = 40000000;
  localparam int unsigned ResetSeconds = 8;
  localparam longint unsigned ResetCycles = longint'(ResetSeconds) * longint'(ClkHz);
  localparam logic [7:0] CtrlReset = 8'h00;
  localparam int BitRing = 7;
  localparam int BitTalk = 6;
  localparam int BitLoop = 5;
  localparam int BitOrig = 4;
  localparam int BitTol = 3;
  localparam int BitTermRdy = 2;
  localparam int BitLowPwr = 1;
  localparam int BitPwrRst = 0;
  localparam logic [1:0] AddrCtrl = 2'h0;
  localparam logic [1:0] AddrStat = 2'h1;
  localparam logic [1:0] AddrCmd = 2'h2;
  typedef enum logic [2:0] {
    MLCR_ONHOOK, MLCR_TALK, MLCR_DATA, MLCR_ORIG, MLCR_ANSWER
  } mlcr_call_t;
endpackage

// file: hw/mlcr_if.sv
// interface: write-only control register path from host to modem
`timescale 1ns/1ps
interface mlcr_if;
  logic wrStb;
  logic [7:0] wrData;
  modport device (input wrStb, input wrData);
  modport host (output wrStb, output wrData);
endinterface

// file: hw/mlcr_device.sv
// modem end: telephone interface control register and call state
// How it works
// [RQ1] ring bit forces answer data mode
// [RQ2] talk bit: talk; else loop bit: data/on-hook
// [RQ3] loop bit reports off-hook to core
// [RQ4] loop bit only consulted for talk-bit entry
// [RQ5] originate set-then-clear enters originate data
// [RQ6] host must not leave originate set
// [RQ7] tolerance bit picks stop-bit or all-bit slack
// [RQ8] terminal ready bit mirrors terminal output
// [RQ9] low-power bit stops clocks and amplifiers
// [RQ10] power reset set-then-clear initialises chip
// [RQ11] power reset zeroes all write registers
// [RQ12] host performs power reset after power-on
// [RQ13] host clears power reset before other writes
// [RQ14] full reset takes 8 seconds
// [RQ15] host must not drop calls via reset
// [RQ16] bits hold last write until rewritten
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module mlcr_device import mlcr_pkg::*; #(
  parameter longint unsigned RESET_CYCLES = ResetCycles
) (
  input wire logic clk, // 40 MHz clock
  input wire logic resetn, // async reset, active low
  input wire logic clkEn, // freezes all state when low
  mlcr_if.device bus, // register write path
  input wire logic asyncMode, // 1 when character mode is asynchronous
  output logic [2:0] callState, // current call state code
  output logic offHook, // loop current present to modem core
  output logic answerFilters, // filters set for answer band
  output logic stopOnlySlack, // 25% short stop bit accepted
  output logic allBitSlack, // 2.3% short on all bits accepted
  output logic termReady, // terminal connected indication
  output logic lowPower, // clocks stopped, amplifiers off
  output logic resetBusy // power-up reset still running
);
  logic [7:0] ctrl_r, ctrl_nxt;
  mlcr_call_t call_r, call_nxt;
  logic [63:0] rstCnt_r, rstCnt_nxt;
  logic offHook_r, offHook_nxt, ans_r, ans_nxt, stopS_r, stopS_nxt, allS_r, allS_nxt;
  logic tr_r, tr_nxt, lp_r, lp_nxt;

  wire logic wr = bus.wrStb;
  wire logic origFall = wr && ctrl_r[BitOrig] && !bus.wrData[BitOrig];
  wire logic pwrFall = wr && ctrl_r[BitPwrRst] && !bus.wrData[BitPwrRst];

  always_comb begin
    ctrl_nxt = ctrl_r; // [RQ16]
    call_nxt = call_r;
    rstCnt_nxt = rstCnt_r;
    if (rstCnt_r != 64'h0) begin
      rstCnt_nxt = rstCnt_r - 64'h1; // [RQ14]
    end
    if (pwrFall) begin
      ctrl_nxt = CtrlReset; // [RQ10] [RQ11]
      call_nxt = MLCR_ONHOOK;
      rstCnt_nxt = RESET_CYCLES; // [RQ14]
    end else begin
      if (wr) begin
        ctrl_nxt = bus.wrData; // [RQ16]
      end
      if (ctrl_nxt[BitRing]) begin
        call_nxt = MLCR_ANSWER; // [RQ1]
      end else if (origFall) begin
        call_nxt = MLCR_ORIG; // [RQ5]
      end else if (ctrl_nxt[BitTalk]) begin
        call_nxt = MLCR_TALK; // [RQ2]
      end else if (call_r == MLCR_ORIG || call_r == MLCR_ANSWER) begin
        call_nxt = call_r; // [RQ4] loop bit ignored for these entries
      end else if (ctrl_nxt[BitLoop]) begin
        call_nxt = MLCR_DATA; // [RQ2]
      end else begin
        call_nxt = MLCR_ONHOOK; // [RQ2]
      end
    end
    offHook_nxt = ctrl_nxt[BitLoop]; // [RQ3]
    ans_nxt = call_nxt == MLCR_ANSWER; // [RQ1]
    stopS_nxt = asyncMode && !ctrl_nxt[BitTol]; // [RQ7]
    allS_nxt = asyncMode && ctrl_nxt[BitTol]; // [RQ7]
    tr_nxt = ctrl_nxt[BitTermRdy]; // [RQ8]
    lp_nxt = ctrl_nxt[BitLowPwr]; // [RQ9]
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CtrlReset;
      call_r <= MLCR_ONHOOK;
      rstCnt_r <= 64'h0;
      offHook_r <= 1'b0;
      ans_r <= 1'b0;
      stopS_r <= 1'b0;
      allS_r <= 1'b0;
      tr_r <= 1'b0;
      lp_r <= 1'b0;
    end else if (clkEn) begin
      ctrl_r <= ctrl_nxt;
      call_r <= call_nxt;
      rstCnt_r <= rstCnt_nxt;
      offHook_r <= offHook_nxt;
      ans_r <= ans_nxt;
      stopS_r <= stopS_nxt;
      allS_r <= allS_nxt;
      tr_r <= tr_nxt;
      lp_r <= lp_nxt;
    end
  end

  logic busy_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_r <= 1'b0;
    end else if (clkEn) begin
      busy_r <= rstCnt_nxt != 64'h0;
    end
  end

  assign callState = call_r;
  assign offHook = offHook_r;
  assign answerFilters = ans_r;
  assign stopOnlySlack = stopS_r;
  assign allBitSlack = allS_r;
  assign termReady = tr_r;
  assign lowPower = lp_r;
  assign resetBusy = busy_r;
endmodule

// file: hw/mlcr_host.sv
// host end: register port commands turned into control register writes
`timescale 1ns/1ps
module mlcr_host import mlcr_pkg::*; #(
  parameter longint unsigned RESET_CYCLES = ResetCycles
) (
  input wire logic clk, // 40 MHz clock
  input wire logic resetn, // async reset, active low
  input wire logic clkEn, // freezes all state when low
  input wire logic [1:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  mlcr_if.host bus // modem control path
);
  typedef enum logic [1:0] {MLCR_IDLE, MLCR_RST_LO, MLCR_WAIT} mlcr_hst_t;
  mlcr_hst_t st_r, st_nxt;
  logic [7:0] shadow_r, shadow_nxt, rdata_r, rdata_nxt, wd_r, wd_nxt;
  logic stb_r, stb_nxt, pulseOrig_r, pulseOrig_nxt;
  logic [63:0] cnt_r, cnt_nxt;

  always_comb begin
    st_nxt = st_r;
    shadow_nxt = shadow_r;
    stb_nxt = 1'b0;
    wd_nxt = wd_r;
    cnt_nxt = cnt_r;
    pulseOrig_nxt = 1'b0;
    rdata_nxt = 8'h00;
    if (rd) begin
      unique case (addr)
        AddrCtrl: rdata_nxt = shadow_r;
        AddrStat: rdata_nxt = {7'h00, st_r != MLCR_IDLE};
        default: rdata_nxt = 8'h00;
      endcase
    end
    unique case (st_r)
      MLCR_IDLE: begin
        if (pulseOrig_r) begin
          stb_nxt = 1'b1; // [RQ5] [RQ6] originate returned to zero
          wd_nxt = shadow_r;
        end else if (wr && addr == AddrCmd && wdata[0]) begin
          stb_nxt = 1'b1; // [RQ10] [RQ12] reset set phase
          wd_nxt = 8'h01;
          shadow_nxt = 8'h00;
          st_nxt = MLCR_RST_LO;
        end else if (wr && addr == AddrCtrl) begin
          stb_nxt = 1'b1; // [RQ8] software keeps terminal ready bit
          shadow_nxt = wdata & 8'hee; // [RQ15] reset never via this path
          wd_nxt = wdata & 8'hfe;
          pulseOrig_nxt = wdata[BitOrig]; // [RQ5]
        end
      end
      MLCR_RST_LO: begin
        stb_nxt = 1'b1; // [RQ13] clear reset before any other bit
        wd_nxt = 8'h00;
        cnt_nxt = RESET_CYCLES;
        st_nxt = MLCR_WAIT;
      end
      MLCR_WAIT: begin
        if (cnt_r <= 64'h1) begin
          st_nxt = MLCR_IDLE; // [RQ14]
        end else begin
          cnt_nxt = cnt_r - 64'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= MLCR_IDLE;
      shadow_r <= 8'h00;
      stb_r <= 1'b0;
      wd_r <= 8'h00;
      cnt_r <= 64'h0;
      pulseOrig_r <= 1'b0;
      rdata_r <= 8'h00;
    end else if (clkEn) begin
      st_r <= st_nxt;
      shadow_r <= shadow_nxt;
      stb_r <= stb_nxt;
      wd_r <= wd_nxt;
      cnt_r <= cnt_nxt;
      pulseOrig_r <= pulseOrig_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign bus.wrStb = stb_r;
  assign bus.wrData = wd_r;
  assign rdata = rdata_r;
endmodule

// file: verif/mlcr_props.sv
// checker: control path write rules and modem end responses
`timescale 1ns/1ps
module mlcr_props import mlcr_pkg::*; (
  input wire logic clk, // clock
  input wire logic resetn, // async reset, active low
  input wire logic wrStb, // control write strobe
  input wire logic [7:0] wrData, // control byte
  input wire logic asyncMode, // asynchronous character mode
  input wire logic [2:0] callState, // call state code
  input wire logic offHook, // loop current present
  input wire logic answerFilters, // answer band filters
  input wire logic stopOnlySlack, // stop bit slack
  input wire logic allBitSlack, // all bit slack
  input wire logic termReady, // terminal connected
  input wire logic lowPower, // low power mode
  input wire logic resetBusy // power-up reset running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_orig;
    wrStb && wrData[4] && wrData[7:6] == 2'h0 ##1 wrStb && wrData[7:6] == 2'h0;
  endsequence
  sequence s_power_up_reset_pulse;
    wrStb && wrData[0] ##1 wrStb && wrData == 8'h00;
  endsequence
  a_orig_returns: assert property (wrStb && wrData[4] |=> wrStb && !wrData[4])
    else $error("originate bit left set");
  a_rst_returns: assert property (wrStb && wrData[0] |=> wrStb && wrData == 8'h00)
    else $error("power reset bit not cleared alone");
  a_orig_state: assert property (s_orig |=> callState == MLCR_ORIG)
    else $error("originate pulse did not enter originate");
  a_ring_answer: assert property (wrStb && wrData[7] |=> callState == MLCR_ANSWER && answerFilters)
    else $error("ring did not enter answer");
  a_talk_state: assert property (wrStb && wrData[7:6] == 2'h1 && !wrData[4]
    |=> callState == MLCR_TALK)
    else $error("talk bit did not enter talk");
  a_loop_hook: assert property (wrStb && !wrData[0] |=> offHook == $past(wrData[5]))
    else $error("off-hook does not follow loop bit");
  a_term_power: assert property (wrStb && !wrData[0]
    |=> termReady == $past(wrData[2]) && lowPower == $past(wrData[1]))
    else $error("terminal or power bit not applied");
  a_slack_pick: assert property (wrStb && !wrData[0] && asyncMode ##1 asyncMode
    |-> allBitSlack == $past(wrData[3]) && stopOnlySlack == !$past(wrData[3]))
    else $error("timing tolerance wrong");
  a_reset_clear: assert property (s_power_up_reset_pulse |=> resetBusy && callState == MLCR_ONHOOK
    && !termReady && !offHook)
    else $error("power reset did not clear state");
  a_state_holds: assert property (!wrStb |=> $stable(callState) && $stable(termReady))
    else $error("state changed without a write");
endmodule

// file: verif/tb.sv
// testbench: host and modem ends joined by the control interface
`timescale 1ns/1ps
module tb import mlcr_pkg::*;;
  localparam longint unsigned RstCyc = 40;
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, asyncMode = 1'b1, clkEn = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, v;
  logic [2:0] callState;
  logic offHook, answerFilters, stopOnlySlack, allBitSlack, termReady, lowPower, resetBusy;
  int errorCnt = 0, nTests = 0, cnt;
  mlcr_if bus();
  mlcr_host #(.RESET_CYCLES(RstCyc)) i_mlcr_host(.clk, .resetn, .clkEn, .addr, .wdata,
    .wr, .rd, .rdata, .bus);
  mlcr_device #(.RESET_CYCLES(RstCyc)) i_mlcr_device(.clk, .resetn, .clkEn, .bus,
    .asyncMode, .callState, .offHook, .answerFilters, .stopOnlySlack, .allBitSlack,
    .termReady, .lowPower, .resetBusy);
  mlcr_props u_props(.clk, .resetn, .wrStb(bus.wrStb), .wrData(bus.wrData), .asyncMode,
    .callState, .offHook, .answerFilters, .stopOnlySlack, .allBitSlack, .termReady,
    .lowPower, .resetBusy);
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    nTests++;
    if (g !== e) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic rreg(input logic [1:0] a);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic t_reset;
    wreg(2'h2, 8'h01);
    rreg(2'h1);
    chk("busy", 8'h01, v & 8'h01);
    wreg(2'h0, 8'h04);
    chk("refused", 8'h00, 8'(termReady));
    cnt = 0;
    while (resetBusy === 1'b1 && cnt < 200) begin
      @(posedge clk);
      cnt++;
    end
    #1;
    chk("resetLen", 8'h01, 8'(cnt > 0 && cnt < RstCyc));
    chk("cleared", 8'h00, {offHook, termReady, lowPower, 2'(0), callState});
    rreg(2'h1);
    chk("done", 8'h00, v & 8'h01);
  endtask
  task automatic t_modes;
    wreg(2'h0, 8'h60);
    chk("talk", 8'(MLCR_TALK), 8'(callState));
    wreg(2'h0, 8'h20);
    chk("data", {4'h1, 1'b0, MLCR_DATA}, {3'h0, offHook, 1'b0, callState});
    wreg(2'h0, 8'h00);
    chk("onhook", 8'(MLCR_ONHOOK), {3'h0, offHook, 1'b0, callState});
  endtask
  task automatic t_orig;
    wreg(2'h0, 8'h10);
    chk("orig", 8'(MLCR_ORIG), 8'(callState));
    wreg(2'h0, 8'h00);
    chk("origHold", 8'(MLCR_ORIG), 8'(callState));
    wreg(2'h0, 8'h80);
    chk("answer", {4'h1, 1'b0, MLCR_ANSWER}, {3'h0, answerFilters, 1'b0, callState});
  endtask
  task automatic t_bits;
    wreg(2'h0, 8'h0e);
    chk("bits", 8'h0b, {4'h0, allBitSlack, stopOnlySlack, termReady, lowPower});
    rreg(2'h0);
    chk("shadow", 8'h0e, v);
    @(posedge clk);
    #1;
    chk("rdIdle", 8'h00, rdata);
    @(posedge clk);
    asyncMode <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("syncSlack", 8'h00, {6'h0, allBitSlack, stopOnlySlack});
    @(posedge clk);
    asyncMode <= 1'b1;
    wreg(2'h0, 8'h00);
    chk("bitsOff", 8'h04, {4'h0, allBitSlack, stopOnlySlack, termReady, lowPower});
    wreg(2'h3, 8'h04);
    chk("unmapped", 8'h00, 8'(termReady));
    @(posedge clk);
    clkEn <= 1'b0;
    wreg(2'h0, 8'h04);
    chk("frozen", 8'h00, 8'(termReady));
    @(posedge clk);
    clkEn <= 1'b1;
    wreg(2'h0, 8'h24);
    chk("loopTerm", 8'h03, {6'h0, offHook, termReady});
  endtask
  task automatic tally_and_finish;
    $display("Summary: %0d checks, %0d errors", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #50us;
    errorCnt++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_modes;
    t_orig;
    t_bits;
    t_reset;
    tally_and_finish;
  end
endmodule
